// ==== rtl/timer16_map.svh ====
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
// operation mode encodings (op_mode_bit_high, op_mode_bit_low)
`define OPM_STOP        2'b00
`define OPM_FREE_EDGE   2'b01
`define OPM_FREE_RUN    2'b10
`define OPM_CLR_MATCH   2'b11
// output function select
`define OUTF_NONE       3'h0
`define OUTF_SQUARE     3'h1
`define OUTF_PPG        3'h2
`define OUTF_OS_SOFT    3'h3
`define OUTF_OS_EXT     3'h4
// valid edge select
`define EDGE_FALL       2'b00
`define EDGE_RISE       2'b01
`define EDGE_BOTH       2'b11
// reset values
`define COUNT_RESET     16'h0000
`define CAPCOMP_RESET   16'hffff
`define PRESCALE_RESET  8'h00
// count clocks the input level must persist before an edge is valid
`define FILTER_SAMPLES  2'd2
// valid edges counted before event counting starts
`define EVENT_ARM_EDGES 2'd2
`endif

// ==== rtl/timer16_pkg.sv ====
package timer16_pkg;
    typedef logic [15:0] count_t;
    typedef enum logic [2:0] {
        OS_IDLE  = 3'b001,
        OS_WAIT  = 3'b010,
        OS_PULSE = 3'b100
    } oneshot_state_t;
endpackage : timer16_pkg

// ==== rtl/timer16.sv ====
`timescale 1ns/1ps
`include "timer16_map.svh"
// Function
// [RULE1] input a filtered on ref_clk as count clock, prescaled clock for capture
// [RULE2] capture only after valid edge and level seen on two samples; code waits for the new level on three prescaled samples
// [RULE3] shared pin is capture input b or timer output, never both
// [RULE4] software keeps 0 < second compare < first compare <= ffff in ppg
// [RULE5] ppg period is first+1 clocks, high for second+1 clocks
// [RULE6] software waits for pulse end before retriggering by software
// [RULE7] edge on input a still retriggers software one-shot
// [RULE8] source gives no new trigger during an externally started pulse
// [RULE9] software never writes zero to compare registers in one-shot modes
// [RULE10] counter runs whenever operation mode bits are not both zero
// [RULE11] first match after start may be one count clock early or late
// [RULE12] one-shot works only in free-run or clear-on-edge modes
// [RULE13] both-edge selection on input a disables capture
// [RULE14] source select set: input b edge raises match irq, no capture
// [RULE15] software changes compare registers from the match interrupt
// [RULE16] unsafe second compare load toggles output at each load
// [RULE17] event counting starts after two valid edges
// [RULE18] event count readable from the counter register
// [RULE19] pulse width measurable up to one full counter cycle
// [RULE20] both input pins configured as inputs for dual capture
// [RULE21] inputs pass a sampling noise limiter before use
// [RULE22] counter increments per count clock and wraps to zero
module timer16 #(
    parameter int PRESCALE_W = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  op_mode_bit_high,
    input  wire logic                  op_mode_bit_low,
    input  wire logic [PRESCALE_W-1:0] prescaler_mode_reg,
    input  wire logic                  event_count_mode,
    input  wire logic [1:0]            edge_sel_a,
    input  wire logic [1:0]            edge_sel_b,
    input  wire logic                  first_is_capture,
    input  wire logic                  second_is_capture,
    input  wire logic                  capture_source_select_bit,
    input  wire logic [2:0]            output_function,
    input  wire logic                  shared_pin_is_output,
    input  wire logic                  oneshot_soft_trigger,
    input  wire logic                  first_wr,
    input  wire logic                  second_wr,
    input  wire logic [15:0]           wr_data,
    input  wire logic                  timer_input_a,
    input  wire logic                  shared_port_pin_in,
    output logic                       shared_port_pin_out,
    output logic                       shared_port_pin_oe_n,
    output logic [15:0]                count_register,
    output logic [15:0]                capcomp_reg_first,
    output logic [15:0]                capcomp_reg_second,
    output logic                       match_irq_first,
    output logic                       match_irq_second,
    output logic                       overflow_flag
);
    logic [1:0]            op_mode;
    logic                  running;
    logic [1:0]            sync_a;
    logic [1:0]            sync_b;
    logic [PRESCALE_W-1:0] pre_cnt;
    logic                  pre_tick;
    logic [1:0]            hist_fast_a;
    logic [2:0]            hist_slow_a;
    logic [2:0]            hist_slow_b;
    logic                  edge_fast_a;
    logic                  edge_slow_a;
    logic                  edge_slow_b;
    logic [1:0]            arm_cnt;
    logic                  count_tick;
    logic                  match_first;
    logic                  match_second;
    logic                  os_trigger;
    logic                  level_out;
    timer16_pkg::oneshot_state_t os_state;

    assign op_mode = {op_mode_bit_high, op_mode_bit_low};
    assign running = (op_mode != `OPM_STOP); // [RULE10]

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev,
                                      input logic cur);
        case (sel)
            `EDGE_FALL: edge_hit = prev & ~cur;
            `EDGE_RISE: edge_hit = ~prev & cur;
            `EDGE_BOTH: edge_hit = prev ^ cur;
            default:    edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // two flops before any logic reads the pins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync_a <= 2'b00;
            sync_b <= 2'b00;
        end else begin
            sync_a <= {sync_a[0], timer_input_a};
            sync_b <= {sync_b[0], shared_port_pin_in};
        end
    end

    // prescaled count clock as a one-cycle enable
    always_ff @(posedge ref_clk) begin
        if (srst || !running) begin
            pre_cnt <= '0;
        end else if (pre_tick) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end
    assign pre_tick = running && (pre_cnt >= prescaler_mode_reg);

    // noise limiter: an edge counts once the new level held two ref_clk samples, or three prescaled samples on the capture path
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hist_fast_a <= 2'b00;
            hist_slow_a <= 3'b000;
            hist_slow_b <= 3'b000;
        end else begin
            hist_fast_a <= {hist_fast_a[0], sync_a[1]}; // [RULE1] [RULE21]
            if (pre_tick) begin
                hist_slow_a <= {hist_slow_a[1:0], sync_a[1]}; // [RULE1]
                hist_slow_b <= {hist_slow_b[1:0], sync_b[1]};
            end
        end
    end
    // fast path: level stable for two ref_clk samples after a change
    assign edge_fast_a = running && (hist_fast_a[0] == sync_a[1]) &&
                         edge_hit(edge_sel_a, hist_fast_a[1], hist_fast_a[0]);
    assign edge_slow_a = running && pre_tick &&
                         (hist_slow_a[1] == hist_slow_a[0]) &&
                         (hist_slow_a[0] == sync_a[1]) &&
                         edge_hit(edge_sel_a, hist_slow_a[2],
                                  hist_slow_a[1]); // [RULE2]
    assign edge_slow_b = running && pre_tick && !shared_pin_is_output &&
                         (hist_slow_b[1] == hist_slow_b[0]) &&
                         (hist_slow_b[0] == sync_b[1]) &&
                         edge_hit(edge_sel_b, hist_slow_b[2],
                                  hist_slow_b[1]); // [RULE2] [RULE3]

    // event counting arms after two valid edges
    always_ff @(posedge ref_clk) begin
        if (srst || !running) begin
            arm_cnt <= 2'd0;
        end else if (event_count_mode && edge_fast_a &&
                     arm_cnt < `EVENT_ARM_EDGES) begin
            arm_cnt <= arm_cnt + 2'd1; // [RULE17]
        end
    end
    assign count_tick = event_count_mode
        ? (edge_fast_a && arm_cnt == `EVENT_ARM_EDGES) // [RULE17]
        : pre_tick;

    assign match_first  = count_tick && (count_register == capcomp_reg_first);
    assign match_second = count_tick && (count_register == capcomp_reg_second);
    // edge on input a retriggers the one-shot in either one-shot mode
    assign os_trigger = (op_mode != `OPM_CLR_MATCH) && edge_slow_a &&
        (output_function == `OUTF_OS_EXT ||
         output_function == `OUTF_OS_SOFT); // [RULE7] [RULE12]

    // counter: starting immediately on mode write means the first match
    // lands within one count clock of nominal
    always_ff @(posedge ref_clk) begin
        if (srst || !running) begin
            count_register <= `COUNT_RESET;
        end else if ((op_mode == `OPM_FREE_EDGE && !event_count_mode &&
                      edge_slow_a) || os_trigger) begin
            count_register <= `COUNT_RESET; // [RULE11]
        end else if (count_tick) begin
            if (op_mode == `OPM_CLR_MATCH && match_first) begin
                count_register <= `COUNT_RESET;
            end else begin
                count_register <= count_register + 16'h0001; // [RULE22]
            end
        end
    end
    // event count is read straight from count_register [RULE18]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            overflow_flag <= 1'b0;
        end else if (count_tick && count_register == 16'hffff) begin
            overflow_flag <= 1'b1; // [RULE19]
        end else if (!running) begin
            overflow_flag <= 1'b0;
        end
    end

    // capture registers; a width over one wrap reads modulo 2^16
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            capcomp_reg_first <= `CAPCOMP_RESET;
        end else if (first_wr) begin
            capcomp_reg_first <= wr_data;
        end else if (first_is_capture && edge_sel_a != `EDGE_BOTH) begin
            if (!capture_source_select_bit && edge_slow_b) begin
                capcomp_reg_first <= count_register; // [RULE14] [RULE19]
            end else if (capture_source_select_bit && edge_slow_a) begin
                capcomp_reg_first <= count_register; // [RULE13]
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            capcomp_reg_second <= `CAPCOMP_RESET;
        end else if (second_wr) begin
            capcomp_reg_second <= wr_data;
        end else if (second_is_capture && edge_sel_a != `EDGE_BOTH &&
                     edge_slow_a) begin
            capcomp_reg_second <= count_register; // [RULE13] [RULE20]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            match_irq_first  <= 1'b0;
            match_irq_second <= 1'b0;
        end else begin
            match_irq_first  <= (match_first && !first_is_capture) ||
                (capture_source_select_bit && edge_slow_b); // [RULE14]
            match_irq_second <= match_second && !second_is_capture;
        end
    end

    // one-shot sequencing: wait for second match, pulse until first match
    always_ff @(posedge ref_clk) begin
        if (srst || !running) begin
            os_state <= timer16_pkg::OS_IDLE;
        end else if (os_trigger ||
                     (oneshot_soft_trigger &&
                      output_function == `OUTF_OS_SOFT &&
                      op_mode != `OPM_CLR_MATCH)) begin
            os_state <= timer16_pkg::OS_WAIT; // [RULE7] [RULE12]
        end else begin
            case (os_state)
                timer16_pkg::OS_IDLE:  os_state <= timer16_pkg::OS_IDLE;
                timer16_pkg::OS_WAIT: begin
                    if (match_second) begin
                        os_state <= timer16_pkg::OS_PULSE;
                    end
                end
                timer16_pkg::OS_PULSE: begin
                    if (match_first) begin
                        os_state <= timer16_pkg::OS_IDLE;
                    end
                end
                default: os_state <= timer16_pkg::OS_IDLE;
            endcase
        end
    end

    // output level per function
    always_ff @(posedge ref_clk) begin
        if (srst || !running) begin
            level_out <= 1'b0;
        end else begin
            case (output_function)
                `OUTF_SQUARE: begin
                    if (match_first) begin
                        level_out <= ~level_out;
                    end
                end
                `OUTF_PPG: begin
                    // period first+1, high for second+1 ending at second
                    if (match_first) begin
                        level_out <= 1'b1; // [RULE5]
                    end else if (match_second) begin
                        level_out <= 1'b0; // [RULE5]
                    end else if (second_wr) begin
                        level_out <= ~level_out; // [RULE16]
                    end
                end
                `OUTF_OS_SOFT, `OUTF_OS_EXT:
                    level_out <= (os_state == timer16_pkg::OS_PULSE);
                default: level_out <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            shared_port_pin_out  <= 1'b0;
            shared_port_pin_oe_n <= 1'b1;
        end else begin
            shared_port_pin_out  <= level_out;
            shared_port_pin_oe_n <= ~shared_pin_is_output; // [RULE3]
        end
    end
endmodule : timer16

// ==== dv/timer16_checker.sv ====
`timescale 1ns/1ps
`include "timer16_map.svh"
module timer16_checker #(
    parameter int PRESCALE_W = 8
) (
    input wire logic                  ref_clk,
    input wire logic                  srst,
    input wire logic                  op_mode_bit_high,
    input wire logic                  op_mode_bit_low,
    input wire logic [PRESCALE_W-1:0] prescaler_mode_reg,
    input wire logic                  event_count_mode,
    input wire logic [1:0]            edge_sel_a,
    input wire logic                  first_is_capture,
    input wire logic                  second_is_capture,
    input wire logic                  capture_source_select_bit,
    input wire logic [2:0]            output_function,
    input wire logic                  shared_pin_is_output,
    input wire logic                  first_wr,
    input wire logic                  shared_port_pin_oe_n,
    input wire logic [15:0]           count_register,
    input wire logic [15:0]           capcomp_reg_first,
    input wire logic [15:0]           capcomp_reg_second,
    input wire logic                  match_irq_first,
    input wire logic                  match_irq_second,
    input wire logic                  overflow_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic stop = !op_mode_bit_high && !op_mode_bit_low;
    // plain free run at full rate: nothing may clear the counter
    wire logic free = op_mode_bit_high && !op_mode_bit_low &&
        prescaler_mode_reg == '0 && !event_count_mode &&
        output_function == `OUTF_NONE;
    wire logic nocap = capture_source_select_bit && !first_wr &&
        (edge_sel_a == `EDGE_BOTH || edge_sel_a == 2'b10);
    sequence first_hit;
        free && !first_is_capture && count_register == capcomp_reg_first;
    endsequence
    sequence second_hit;
        free && !second_is_capture && count_register == capcomp_reg_second;
    endsequence
    chk_pin_owner: assert property (
        !$past(srst) |-> shared_port_pin_oe_n == !$past(shared_pin_is_output))
        else $error("pin ownership wrong");
    chk_stop_hold: assert property (
        $past(stop) && $past(stop, 2) |-> $stable(count_register))
        else $error("counter moved while stopped");
    chk_count_step: assert property (
        free && $past(free) && $past(free, 2) |->
        count_register == 16'($past(count_register) + 16'h0001))
        else $error("counter step wrong");
    chk_match_first: assert property (
        first_hit |=> match_irq_first)
        else $error("first match irq missing");
    chk_match_second: assert property (
        second_hit |=> match_irq_second)
        else $error("second match irq missing");
    chk_irq_cause: assert property (
        free && $past(free) && !capture_source_select_bit &&
        !first_is_capture && match_irq_first |->
        $past(count_register) == $past(capcomp_reg_first))
        else $error("first irq without match");
    chk_no_capture: assert property (
        $past(nocap) && $past(nocap, 2) |-> $stable(capcomp_reg_first))
        else $error("capture while disabled");
    chk_ovf_clear: assert property (
        $past(stop) |-> !overflow_flag)
        else $error("overflow kept in stop");
endmodule : timer16_checker
bind timer16 timer16_checker #(.PRESCALE_W(PRESCALE_W))
    timer16_checker_i (.*);

// ==== dv/pin_model.sv ====
`timescale 1ns/1ps
module pin_model (
    input  wire logic a_level,
    input  wire logic b_level,
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      timer_input_a,
    output logic      shared_in
);
    // bench moves a_level only between pulses, never inside one
    assign timer_input_a = a_level;
    // the wire follows whoever drives it; b is seen only when released
    assign shared_in = pin_oe_n ? b_level : pin_out;
endmodule : pin_model

// ==== dv/tb_timer16.sv ====
`timescale 1ns/1ps
`include "timer16_map.svh"
module tb_timer16;
    logic        ref_clk, srst, mh, ml, ev, fcap, scap, csel, pout;
    logic        ost, fwr, swr, a_lvl, b_lvl, tia, shin, pin_o, oe_n;
    logic        irq1, irq2, ovf;
    logic [7:0]  pres;
    logic [1:0]  ea, eb;
    logic [2:0]  ofn;
    logic [15:0] wd, cnt, r1, r2, keep;
    int          failures, checked;
    timer16 timer16_i (
        .ref_clk(ref_clk), .srst(srst), .op_mode_bit_high(mh),
        .op_mode_bit_low(ml), .prescaler_mode_reg(pres),
        .event_count_mode(ev), .edge_sel_a(ea), .edge_sel_b(eb),
        .first_is_capture(fcap), .second_is_capture(scap),
        .capture_source_select_bit(csel), .output_function(ofn),
        .shared_pin_is_output(pout), .oneshot_soft_trigger(ost),
        .first_wr(fwr), .second_wr(swr), .wr_data(wd),
        .timer_input_a(tia), .shared_port_pin_in(shin),
        .shared_port_pin_out(pin_o), .shared_port_pin_oe_n(oe_n),
        .count_register(cnt), .capcomp_reg_first(r1),
        .capcomp_reg_second(r2), .match_irq_first(irq1),
        .match_irq_second(irq2), .overflow_flag(ovf));
    pin_model pin_model_i (.a_level(a_lvl), .b_level(b_lvl),
        .pin_out(pin_o), .pin_oe_n(oe_n), .timer_input_a(tia),
        .shared_in(shin));
    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic results;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp16
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic restart;
        {mh, ml} = `OPM_STOP;
        srst = 1;
        tick(8);
        srst = 0;
    endtask : restart
    task automatic wr(input logic sec, input logic [15:0] v);
        fwr = !sec;
        swr = sec;
        wd = v;
        tick(1);
        {fwr, swr} = 2'b00;
        // a quiet cycle keeps back-to-back writes off one strobe
        tick(1);
    endtask : wr
    task automatic wait_irq1(input int n);
        for (int i = 0; i < n && irq1 !== 1'b1; i++) tick(1);
    endtask : wait_irq1
    task automatic until_b(input logic v);
        for (int i = 0; i < 50 && shin !== v; i++) tick(1);
    endtask : until_b
    task automatic hold(input logic v, output int n);
        n = 0;
        while (shin === v && n < 99) begin
            tick(1);
            n++;
        end
    endtask : hold
    task automatic t_reset;
        cmp16(cnt, 16'h0000);
        cmp16(r1, 16'hffff);
        cmp16(r2, 16'hffff);
        cmp16(16'({irq1, irq2, ovf}), 16'h0000);
        cmp16(16'({oe_n, pin_o}), 16'h0002);
    endtask : t_reset
    task automatic t_count;
        restart;
        wr(0, 16'h0010);
        wr(1, 16'h0008);
        {mh, ml} = `OPM_FREE_RUN;
        tick(9);
        cmp16(16'(irq2), 16'h0001);
        cmp16(cnt, 16'h0009);
        tick(1);
        cmp16(16'(irq2), 16'h0000);
        wait_irq1(40);
        cmp16(16'(irq1), 16'h0001);
        cmp16(cnt, 16'h0011);
        tick(1);
        cmp16(16'(irq1), 16'h0000);
    endtask : t_count
    task automatic t_ppg;
        int hi;
        int per;
        restart;
        {pout, ofn} = {1'b1, `OUTF_PPG};
        wr(0, 16'h0009);
        wr(1, 16'h0003);
        {mh, ml} = `OPM_CLR_MATCH;
        until_b(0);
        until_b(1);
        hi = 0;
        per = 0;
        while (shin === 1'b1 && per < 99) begin
            tick(1);
            hi++;
            per++;
        end
        while (shin === 1'b0 && per < 99) begin
            tick(1);
            per++;
        end
        cmp16(16'(hi), 16'h0004);
        cmp16(16'(per), 16'h000a);
        cmp16(16'(oe_n), 16'h0000);
        restart;
        ofn = `OUTF_SQUARE;
        wr(0, 16'h0004);
        {mh, ml} = `OPM_CLR_MATCH;
        until_b(1);
        hold(1'b1, hi);
        cmp16(16'(hi), 16'h0004 + 16'h0001);
        {pout, ofn} = {1'b0, `OUTF_NONE};
    endtask : t_ppg
    task automatic t_capture;
        restart;
        {fcap, csel, pres, ea} = {2'b11, 8'h01, `EDGE_BOTH};
        {mh, ml} = `OPM_FREE_RUN;
        repeat (4) begin
            a_lvl = ~a_lvl;
            tick(20);
        end
        cmp16(r1, 16'hffff);
        restart;
        ea = `EDGE_RISE;
        {mh, ml} = `OPM_FREE_RUN;
        tick(10);
        a_lvl = 1; // short glitch must be filtered out
        tick(1);
        a_lvl = 0;
        tick(20);
        cmp16(r1, 16'hffff);
        a_lvl = 1;
        tick(20);
        cmp16(16'(r1 !== 16'hffff), 16'h0001);
        keep = r1;
        eb = `EDGE_RISE;
        b_lvl = 1;
        wait_irq1(40);
        cmp16(16'(irq1), 16'h0001);
        cmp16(r1, keep);
        {a_lvl, b_lvl, fcap, csel, pres} = '0;
    endtask : t_capture
    task automatic t_oneshot;
        int n;
        restart;
        {pout, ofn, ea} = {1'b1, `OUTF_OS_SOFT, `EDGE_RISE};
        wr(0, 16'h000c);
        wr(1, 16'h0004);
        {mh, ml} = `OPM_FREE_RUN;
        ost = 1;
        tick(1);
        ost = 0;
        until_b(1);
        hold(1'b1, n);
        cmp16(16'(n), 16'h000c - 16'h0004);
        // input a then stays high: no new trigger during the pulse
        a_lvl = 1;
        until_b(1);
        hold(1'b1, n);
        cmp16(16'(n), 16'h000c - 16'h0004);
        restart;
        wr(0, 16'h000c);
        wr(1, 16'h0004);
        {mh, ml} = `OPM_CLR_MATCH;
        ost = 1;
        tick(1);
        ost = 0;
        hold(1'b0, n);
        cmp16(16'(n), 16'h0063);
        {a_lvl, pout, ofn} = '0;
    endtask : t_oneshot
    task automatic t_event;
        restart;
        {ev, ea} = {1'b1, `EDGE_RISE};
        {mh, ml} = `OPM_FREE_RUN;
        repeat (5) begin
            a_lvl = 1;
            tick(10);
            a_lvl = 0;
            tick(10);
        end
        cmp16(cnt, 16'h0005 - 16'(`EVENT_ARM_EDGES));
    endtask : t_event
    initial begin
        #100000;
        failures++;
        results;
    end
    initial begin
        {srst, mh, ml, ev, fcap, scap, csel, pout, ost, fwr, swr} = '0;
        {a_lvl, b_lvl, pres, eb, wd} = '0;
        ea = `EDGE_RISE;
        ofn = `OUTF_NONE;
        keep = '0;
        failures = 0;
        checked = 0;
        restart;
        t_reset;
        t_count;
        t_ppg;
        t_capture;
        t_oneshot;
        t_event;
        results;
    end
endmodule : tb_timer16
